/* include/cfg_loader_pkg.sv */
package cfg_loader_pkg;

  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [7:0] PREAMBLE_BYTE = 8'hF2;
  localparam logic [7:0] CHECK_BYTE = 8'hD2;
  localparam logic [7:0] START_BYTE = 8'hFE;
  localparam logic [2:0] MODE_BYTE_WIDE = 3'h2;
  localparam int HEADER_LEN = 7;
  localparam int EXTEND_LEN = 5;
  localparam int STARTUP_CLOCKS = 6;
  localparam int FRAME_BYTES_DEFAULT = 16;
  localparam int FRAME_COUNT_DEFAULT = 4;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [3:0] {
    ST_HEADER,
    ST_WAIT_SELECT,
    ST_START,
    ST_DATA,
    ST_CHECK,
    ST_EXTEND,
    ST_STARTUP,
    ST_DONE,
    ST_ERROR
  } load_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } frame_word_t;

endpackage : cfg_loader_pkg

/* design/word_buffer.sv */
`timescale 1ns/100ps

module word_buffer
  import cfg_loader_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire frame_word_t in_word_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output frame_word_t out_word_out
);

  frame_word_t mem [BUF_DEPTH];
  logic [1:0] count;
  logic wr_ptr;
  logic rd_ptr;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;

  assign in_ready_out = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_word_out = mem[rd_ptr];

  always_ff @(posedge core_clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_word_in;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      count <= 2'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end
    else
    begin
      count <= count + {1'b0, push} - {1'b0, pop};
      wr_ptr <= wr_ptr ^ push;
      rd_ptr <= rd_ptr ^ pop;
    end
  end

endmodule : word_buffer

/* design/byte_wide_config_loader.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Whole byte taken per rising configuration clock.
// - No CRC; only constant check fields verified.
// - No length count; loading ends after last frame, extend and start-up clocks.
// - Byte-wide mode needs mode pins 010.
// - Frames accepted only when selected, not full.
// - Chain status High until seven-byte header loaded.
// - Chain status Low after header.
// - Chain status High once memory is full.
// - First chain-select tied High; internal pull-up.
// - User I/O enabled only after completion High.
// - Completion pin open-drain, never drives High.
// - Unwired completion pin: active when configured.
// - Header: FF FF, F2, FF FF FF, D2.
// - Frame: start FE, data, check; extend pattern.
// - Frame closing byte must equal D2.
// - Leftmost stream bit sits on data line 0.
// - On error stop loading, pull error pin Low.

module byte_wide_config_loader
  import cfg_loader_pkg::*;
#(
  parameter int FRAME_BYTES = FRAME_BYTES_DEFAULT,
  parameter int FRAME_COUNT = FRAME_COUNT_DEFAULT
)
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic cfg_clock_in,
  input wire logic [7:0] cfg_byte_in,
  input wire logic mode_sel_2_in,
  input wire logic mode_sel_1_in,
  input wire logic mode_sel_0_in,
  input wire logic chain_select_in,
  input wire logic reprogram_n_in,
  input wire logic done_in,
  output logic chain_status_out,
  output logic done_out,
  output logic done_oe_out,
  output logic error_n_out,
  output logic error_n_oe_out,
  output logic high_during_cfg_out,
  output logic low_during_cfg_out,
  output logic user_io_enable_out,
  output logic frame_valid_out,
  input wire logic frame_ready_in,
  output frame_word_t frame_word_out
);

  // Every configuration pin passes two or more flops before any logic reads it; srst_in and frame_ready_in are read directly.
  logic [2:0] clk_sync;
  logic [7:0] byte_meta;
  logic [7:0] byte_sync;
  logic [7:0] byte_cap;
  logic [2:0] mode_meta;
  logic [2:0] mode_sync;
  logic [1:0] sel_meta;
  logic [1:0] sel_sync;
  logic [1:0] done_meta;
  logic [1:0] done_sync;
  logic [1:0] reprog_sync;
  load_state_t state;
  load_state_t next_state;
  logic [15:0] byte_cnt;
  logic [15:0] next_byte_cnt;
  logic [15:0] frame_cnt;
  logic [15:0] next_frame_cnt;
  logic status;
  logic next_status;
  logic error;
  logic next_error;
  logic released;
  logic push_valid;
  frame_word_t push_word;
  logic buf_ready;

  function automatic logic [7:0] stream_order(input logic [7:0] b);
    // Stream patterns are printed with line 0 leftmost, so reverse into MSB-first form.
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      r[7 - i] = b[i];
    end
    return r;
  endfunction : stream_order

  function automatic logic [2:0] hdr_idx(input logic [15:0] n);
    hdr_idx = n[2:0];
  endfunction : hdr_idx

  always_ff @(posedge core_clk_in)
  begin
    clk_sync <= {clk_sync[1:0], cfg_clock_in};
    byte_meta <= cfg_byte_in;
    byte_sync <= byte_meta;
    mode_meta <= {mode_sel_2_in, mode_sel_1_in, mode_sel_0_in};
    mode_sync <= mode_meta;
    sel_meta <= {sel_meta[0], chain_select_in};
    sel_sync <= {sel_sync[0], sel_meta[1]};
    done_meta <= {done_meta[0], done_in};
    done_sync <= {done_sync[0], done_meta[1]};
    reprog_sync <= {reprog_sync[0], reprogram_n_in};
    byte_cap <= byte_sync;
  end

  // The data path is one flop deeper than the clock path, so the byte seen
  // at a detected rise is the value that stood before that rise.
  wire clk_rise = clk_sync[1] && !clk_sync[2];
  wire [7:0] stream_byte = stream_order(byte_cap);
  wire mode_ok = (mode_sync == MODE_BYTE_WIDE);
  wire selected = sel_sync[1];
  // The reprogram pin is asynchronous too, so a restart lands two cycles after the pin falls.
  wire restart_req = !reprog_sync[1];
  wire active = mode_ok && !error && !restart_req;
  wire take = clk_rise && active;
  wire [7:0] hdr_expect = (hdr_idx(byte_cnt) == 3'h2) ? PREAMBLE_BYTE :
                          (hdr_idx(byte_cnt) == 3'h6) ? CHECK_BYTE : FILL_BYTE;
  wire [7:0] ext_expect = (byte_cnt == 16'h0001) ? CHECK_BYTE : FILL_BYTE;

  always_comb
  begin
    next_state = state;
    next_byte_cnt = byte_cnt;
    next_frame_cnt = frame_cnt;
    next_status = status;
    next_error = error;
    push_valid = 1'b0;
    push_word = '{data: stream_byte, last: 1'b0};
    if (take)
    begin
      case (state)
        ST_HEADER:
        begin
          if (stream_byte != hdr_expect)
          begin
            next_error = 1'b1;
          end
          else if (byte_cnt == 16'(HEADER_LEN - 1))
          begin
            next_state = ST_WAIT_SELECT;
            next_byte_cnt = 16'h0000;
            next_status = 1'b0;
          end
          else
          begin
            next_byte_cnt = byte_cnt + 16'h0001;
          end
        end
        ST_WAIT_SELECT, ST_START:
        begin
          // Bytes meant for upstream devices pass by while deselected.
          if (selected)
          begin
            if (stream_byte == START_BYTE)
            begin
              next_state = ST_DATA;
              next_byte_cnt = 16'h0000;
            end
            else if (state == ST_START)
            begin
              next_error = 1'b1;
            end
          end
        end
        ST_DATA:
        begin
          // A stall by the receiver is absorbed by the buffer; a full buffer drops the byte and raises the error.
          push_valid = buf_ready;
          push_word.last = (byte_cnt == 16'(FRAME_BYTES - 1));
          if (!buf_ready)
          begin
            next_error = 1'b1;
          end
          else if (byte_cnt == 16'(FRAME_BYTES - 1))
          begin
            next_state = ST_CHECK;
          end
          next_byte_cnt = byte_cnt + 16'h0001;
        end
        ST_CHECK:
        begin
          next_byte_cnt = 16'h0000;
          if (stream_byte != CHECK_BYTE)
          begin
            next_error = 1'b1;
          end
          else if (frame_cnt == 16'(FRAME_COUNT - 1))
          begin
            next_state = ST_EXTEND;
            next_status = 1'b1;
          end
          else
          begin
            next_frame_cnt = frame_cnt + 16'h0001;
            next_state = ST_START;
          end
        end
        ST_EXTEND:
        begin
          if (stream_byte != ext_expect)
          begin
            next_error = 1'b1;
          end
          else if (byte_cnt == 16'(EXTEND_LEN - 1))
          begin
            next_state = ST_STARTUP;
            next_byte_cnt = 16'h0000;
          end
          else
          begin
            next_byte_cnt = byte_cnt + 16'h0001;
          end
        end
        ST_STARTUP:
        begin
          // Start-up bytes are don't-cares; only their clocks count.
          if (byte_cnt == 16'(STARTUP_CLOCKS - 1))
          begin
            next_state = ST_DONE;
          end
          next_byte_cnt = byte_cnt + 16'h0001;
        end
        default:
        begin
          next_state = state;
        end
      endcase
    end
    if (next_error)
    begin
      next_state = ST_ERROR;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in || restart_req)
    begin
      state <= ST_HEADER;
      byte_cnt <= 16'h0000;
      frame_cnt <= 16'h0000;
      status <= 1'b1;
      error <= 1'b0;
      released <= 1'b0;
    end
    else
    begin
      state <= next_state;
      byte_cnt <= next_byte_cnt;
      frame_cnt <= next_frame_cnt;
      status <= next_status;
      error <= next_error;
      released <= (state == ST_DONE);
    end
  end

  word_buffer u_buffer (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .in_valid_in(push_valid),
    .in_ready_out(buf_ready),
    .in_word_in(push_word),
    .out_valid_out(frame_valid_out),
    .out_ready_in(frame_ready_in),
    .out_word_out(frame_word_out)
  );

  assign chain_status_out = status;
  // The completion pin only ever sinks; release lets the wired net rise.
  assign done_out = 1'b0;
  assign done_oe_out = !released;
  // Waiting on the wired net holds all chained devices until the last one finishes.
  assign user_io_enable_out = released && done_sync[1];
  assign error_n_out = 1'b0;
  assign error_n_oe_out = error;
  assign high_during_cfg_out = !released;
  assign low_during_cfg_out = released;

endmodule : byte_wide_config_loader

/* tb/cfg_loader_assertions.sv */
`timescale 1ns/100ps
module cfg_loader_assertions
  import cfg_loader_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic mode_sel_2_in,
  input wire logic mode_sel_1_in,
  input wire logic mode_sel_0_in,
  input wire logic reprogram_n_in,
  input wire logic done_in,
  input wire logic frame_ready_in,
  input wire logic chain_status_out,
  input wire logic done_out,
  input wire logic done_oe_out,
  input wire logic error_n_out,
  input wire logic error_n_oe_out,
  input wire logic high_during_cfg_out,
  input wire logic low_during_cfg_out,
  input wire logic user_io_enable_out,
  input wire logic frame_valid_out,
  input wire frame_word_t frame_word_out
);
  default clocking dc @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);
  a_done_open_drain: assert property (done_out == 1'h0) else $error("done driven high");
  a_error_open_drain: assert property (error_n_out == 1'h0) else $error("error driven");
  a_reprogram_clears: assert property (!reprogram_n_in |=> ##2
    (chain_status_out && done_oe_out && !error_n_oe_out)) else $error("restart state wrong");
  a_io_after_done: assert property (user_io_enable_out |-> done_in && !done_oe_out)
    else $error("io enabled early");
  a_io_follows_net: assert property ((!done_oe_out && done_in) [*5] |-> user_io_enable_out)
    else $error("io not enabled");
  a_hdc_ldc_pair: assert property (high_during_cfg_out != low_during_cfg_out)
    else $error("hdc ldc equal");
  a_error_freezes: assert property ($past(error_n_oe_out) && error_n_oe_out |->
    $stable(chain_status_out) && done_oe_out) else $error("loading after error");
  a_mode_gate: assert property (({mode_sel_2_in, mode_sel_1_in, mode_sel_0_in} !=
    MODE_BYTE_WIDE && reprogram_n_in) [*3] |=> $stable(chain_status_out))
    else $error("mode ignored");
  a_release_full: assert property ($fell(done_oe_out) |->
    chain_status_out && !error_n_oe_out) else $error("early release");
  a_word_holds: assert property (frame_valid_out && !frame_ready_in |=>
    frame_valid_out && $stable(frame_word_out)) else $error("word dropped");
  c_release: cover property ($fell(done_oe_out));
  c_error: cover property ($rose(error_n_oe_out));
  c_stall: cover property (frame_valid_out && !frame_ready_in);
endmodule : cfg_loader_assertions
bind byte_wide_config_loader cfg_loader_assertions chk (.*);

/* tb/cfg_source_model.sv */
`timescale 1ns/100ps
module cfg_source_model
(
  output logic cfg_clock_out,
  output logic [7:0] cfg_byte_out
);
  initial
  begin
    cfg_clock_out = 1'h0;
    cfg_byte_out = 8'h00;
  end
  // The clock only runs while a byte is sent, and a released bus shows the inverse.
  task automatic send(input logic [7:0] b);
    cfg_byte_out <= b;
    #40 cfg_clock_out <= 1'h1;
    #62.5 cfg_clock_out <= 1'h0;
    cfg_byte_out <= ~b;
    #22.5;
  endtask : send
endmodule : cfg_source_model

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import cfg_loader_pkg::*;
  localparam int FB = 2;
  localparam int FC = 2;
  logic core_clk_in = 1'h0, srst_in = 1'h1, reprogram_n_in = 1'h1, chain_select_in = 1'h1;
  logic frame_ready_in = 1'h1, stall = 1'h0, peer_low = 1'h0, done_in;
  logic mode_sel_2_in = 1'h0, mode_sel_1_in = 1'h1, mode_sel_0_in = 1'h0;
  logic cfg_clock_in, chain_status_out, done_out, done_oe_out, error_n_out, error_n_oe_out;
  logic high_during_cfg_out, low_during_cfg_out, user_io_enable_out, frame_valid_out;
  logic [7:0] cfg_byte_in;
  frame_word_t frame_word_out;
  frame_word_t exp_q[$];
  int err_total = 0, num_checks = 0, seed = 42;
  logic [7:0] hdr[7] = '{FILL_BYTE, FILL_BYTE, PREAMBLE_BYTE, FILL_BYTE, FILL_BYTE, FILL_BYTE,
    CHECK_BYTE};
  logic [7:0] ext[5] = '{FILL_BYTE, CHECK_BYTE, FILL_BYTE, FILL_BYTE, FILL_BYTE};
  // Wired completion net with its pull-up; a peer device may hold it low.
  assign done_in = !(done_oe_out | peer_low);
  byte_wide_config_loader #(.FRAME_BYTES(FB), .FRAME_COUNT(FC)) uut (.*);
  cfg_source_model src (.cfg_clock_out(cfg_clock_in), .cfg_byte_out(cfg_byte_in));
  initial forever #2.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) frame_ready_in <= !stall && 1'($random(seed));
  always @(posedge core_clk_in)
    if (frame_valid_out === 1'h1 && frame_ready_in)
      check(frame_word_out, exp_q.size() ? exp_q.pop_front() : 9'h1FF ^ frame_word_out);
  function automatic logic [7:0] pin(input logic [7:0] s);
    for (int i = 0; i < 8; i++) pin[i] = s[7 - i];
  endfunction : pin
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic restart;
    @(posedge core_clk_in) reprogram_n_in <= 1'h0;
    repeat (2) @(posedge core_clk_in);
    reprogram_n_in <= 1'h1;
    repeat (4) @(posedge core_clk_in);
  endtask : restart
  task automatic header(input logic [7:0] chk);
    foreach (hdr[i])
    begin
      if (i == 6) check(chain_status_out, 1'h1);
      src.send(pin(i == 6 ? chk : hdr[i]));
    end
  endtask : header
  task automatic frames(input logic [7:0] chk, input int kept);
    logic [7:0] b;
    for (int f = 0; f < FC; f++)
    begin
      src.send(pin(START_BYTE));
      for (int i = 0; i < FB; i++)
      begin
        b = 8'($random(seed));
        if (f < kept) exp_q.push_back({b, i == FB - 1});
        src.send(pin(b));
      end
      src.send(pin(chk));
    end
  endtask : frames
  task automatic drain;
    @(posedge core_clk_in) stall <= 1'h0;
    repeat (200) if (exp_q.size() != 0) @(posedge core_clk_in);
    check(exp_q.size() == 0, 1'h1);
    if (exp_q.size() != 0) end_of_test();
  endtask : drain
  initial
  begin
    repeat (2) @(posedge core_clk_in);
    srst_in <= 1'h0;
    for (int m = 0; m < 8; m++)
    begin
      {mode_sel_2_in, mode_sel_1_in, mode_sel_0_in} <= 3'(m);
      restart();
      header(CHECK_BYTE);
      check(chain_status_out, m != MODE_BYTE_WIDE);
    end
    $display("test mode pins done");
    {mode_sel_2_in, mode_sel_1_in, mode_sel_0_in} <= MODE_BYTE_WIDE;
    restart();
    header(CHECK_BYTE);
    @(posedge core_clk_in) chain_select_in <= 1'h0;
    frames(CHECK_BYTE, 0);
    check(chain_status_out, 1'h0);
    @(posedge core_clk_in) chain_select_in <= 1'h1;
    peer_low <= 1'h1;
    frames(CHECK_BYTE, FC);
    check(chain_status_out, 1'h1);
    foreach (ext[i]) src.send(pin(ext[i]));
    check(done_oe_out, 1'h1);
    repeat (STARTUP_CLOCKS) src.send(8'(seed));
    repeat (8) @(posedge core_clk_in);
    check({done_oe_out, user_io_enable_out, error_n_oe_out}, 3'h0);
    @(posedge core_clk_in) peer_low <= 1'h0;
    repeat (8) @(posedge core_clk_in);
    check(user_io_enable_out, 1'h1);
    drain();
    $display("test chain load done");
    restart();
    header(CHECK_BYTE);
    @(posedge core_clk_in) stall <= 1'h1;
    frames(8'h00, 1);
    check({error_n_oe_out, chain_status_out}, 2'h2);
    drain();
    $display("test frame check done");
    restart();
    check(error_n_oe_out, 1'h0);
    header(8'h00);
    check(error_n_oe_out, 1'h1);
    $display("test header check done");
    end_of_test();
  end
endmodule : testbench
